// ==== hw/comm_loss_pkg.sv ====
// Contract
// RULE_01 - internal-link action 0: no protective action on internal link loss.
// RULE_02 - internal-link action 1: block inverter output at once, motor coasts.
// RULE_03 - internal-link action 2: ramp to stop over the trip deceleration time.
// RULE_04 - internal-link action 3: warn on outputs whose function selection is 13.
// RULE_05 - internal-link action 4: run at the stored fallback preset.
// RULE_06 - internal link is lost only after loss lasts the internal loss time.
// RULE_07 - actions 1 and 2 are reported as a level trip, not a warning.
// RULE_08 - action 3 and the fallback preset action are reported as a warning.
// RULE_09 - usb action 0: no protective action on usb loss.
// RULE_10 - usb action 1: block inverter output at once, motor coasts.
// RULE_11 - usb action 2: ramp to stop over the trip deceleration time.
// RULE_12 - usb action 3: warn on outputs whose function selection is 13.
// RULE_13 - usb action 4: keep running at the fallback preset.
// RULE_14 - usb lost only after loss lasts usb loss time, 0.1 to 120.0 s.
// RULE_15 - speed unit 1 selects the preset speed in rpm instead of hertz.
// RULE_16 - each loss timer clears and restarts when the link recovers.
`default_nettype none
package comm_loss_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL         = 4'h0;
  localparam logic [3:0] ADDR_INT_TIME     = 4'h1;
  localparam logic [3:0] ADDR_USB_TIME     = 4'h2;
  localparam logic [3:0] ADDR_PRESET_FREQ  = 4'h3;
  localparam logic [3:0] ADDR_PRESET_SPEED = 4'h4;
  localparam logic [3:0] ADDR_DECEL        = 4'h5;
  localparam logic [3:0] ADDR_DO_SEL       = 4'h6;
  localparam logic [3:0] ADDR_STATUS       = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STAT     = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h9;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int CTRL_ACT_INT_LSB = 0;
  localparam int CTRL_ACT_USB_LSB = 4;
  localparam int CTRL_RPM_BIT     = 8;
  localparam int DO_SEL_W         = 8;
  localparam int NUM_DO           = 3;
  localparam int TIME_W           = 11;

  // ****************************************************************
  // codes and reset values
  // ****************************************************************
  localparam logic [2:0] ACT_NONE   = 3'h0;
  localparam logic [2:0] ACT_COAST  = 3'h1;
  localparam logic [2:0] ACT_DECEL  = 3'h2;
  localparam logic [2:0] ACT_WARN   = 3'h3;
  localparam logic [2:0] ACT_PRESET = 3'h4;
  localparam logic [7:0] DO_FN_LOST = 8'h0d;

  localparam logic [10:0] TIME_MIN   = 11'h001;
  localparam logic [10:0] TIME_MAX   = 11'h4b0;
  localparam logic [10:0] TIME_RESET = 11'h00a;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] DECEL_RESET  = 16'h0000;

  // ****************************************************************
  // timing: loss time counts in tenths of a second
  // ****************************************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

endpackage : comm_loss_pkg
`default_nettype wire

// ==== hw/loss_timer_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface loss_timer_if;
  logic        link_ok;
  logic [10:0] limit;
  logic        lost;
  modport owner (output link_ok, output limit, input lost);
  modport timer (input link_ok, input limit, output lost);
endinterface : loss_timer_if
`default_nettype wire

// ==== hw/loss_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module loss_timer #(
  parameter int TICK_CYCLES = comm_loss_pkg::TICK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  loss_timer_if.timer      tif
);
  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("tick count too small");
  end

  typedef struct packed {
    logic [PW-1:0] prescale;
    logic [10:0]   tenths;
    logic          lost;
  } timer_state_type;

  timer_state_type st;
  timer_state_type next_st;

  always_comb begin
    next_st = st;
    if (tif.link_ok) begin
      next_st = '0; // RULE_16
    end else if (!st.lost) begin
      if (st.prescale == TICK_LAST) begin
        next_st.prescale = '0;
        next_st.tenths   = st.tenths + 11'h001;
        if (st.tenths + 11'h001 >= tif.limit) begin
          next_st.lost = 1'b1; // RULE_06 RULE_14
        end
      end else begin
        next_st.prescale = st.prescale + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tif.lost = st.lost;
endmodule : loss_timer
`default_nettype wire

// ==== hw/comm_loss_supervisor.sv ====
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module comm_loss_supervisor #(
  parameter int TICK_CYCLES = comm_loss_pkg::TICK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        int_link_ok_i,
  input  wire logic        usb_link_ok_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [31:0] reg_rdata_o,
  output var  logic        free_run_halt_o,
  output var  logic        decel_stop_o,
  output var  logic [15:0] trip_decel_time_o,
  output var  logic        preset_run_o,
  output var  logic        preset_is_rpm_o,
  output var  logic [15:0] preset_value_o,
  output var  logic        trip_o,
  output var  logic        warning_o,
  output var  logic [2:0]  multifunction_digital_outputs_o,
  output var  logic        int_lost_o,
  output var  logic        usb_lost_o,
  output var  logic        irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  ok_meta;
    logic [1:0]  ok_sync;
    logic [2:0]  act_int;
    logic [2:0]  act_usb;
    logic        speed_unit_select;
    logic [10:0] int_time;
    logic [10:0] usb_time;
    logic [15:0] preset_freq;
    logic [15:0] preset_speed;
    logic [15:0] decel;
    logic [23:0] do_sel;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  ev_prev;
    logic [31:0] rdata;
    logic        halt;
    logic        dstop;
    logic        prun;
    logic        prpm;
    logic [15:0] pval;
    logic [15:0] dtime;
    logic        trip;
    logic        warn;
    logic [2:0]  dout;
    logic [1:0]  lost;
    logic        irq;
  } sup_state_type;

  sup_state_type st;
  sup_state_type next_st;

  // ****************************************************************
  // loss timers
  // ****************************************************************
  loss_timer_if tif [2] ();
  logic [1:0] lost_w;

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    assign tif[i].link_ok = st.ok_sync[i];
    assign tif[i].limit   = (i == 0) ? st.int_time : st.usb_time;
    assign lost_w[i]      = tif[i].lost;
    loss_timer #(
      .TICK_CYCLES (TICK_CYCLES)
    ) u_tmr (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .tif       (tif[i])
    );
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [10:0] clamp_time(input logic [31:0] v);
    logic [10:0] r;
    r = v[10:0];
    if (v < 32'(comm_loss_pkg::TIME_MIN)) begin
      r = comm_loss_pkg::TIME_MIN;
    end else if (v > 32'(comm_loss_pkg::TIME_MAX)) begin
      r = comm_loss_pkg::TIME_MAX;
    end
    return r;
  endfunction : clamp_time

  function automatic logic [2:0] clamp_act(input logic [2:0] v);
    logic [2:0] r;
    r = v;
    if (v > comm_loss_pkg::ACT_PRESET) begin
      r = comm_loss_pkg::ACT_NONE;
    end
    return r;
  endfunction : clamp_act

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [2:0] act_int_w;
  logic [2:0] act_usb_w;
  logic       coast_int;
  logic       coast_usb;
  logic       dec_int;
  logic       dec_usb;
  logic       warn_int;
  logic       warn_usb;
  logic       pre_int;
  logic       pre_usb;
  logic       any_warn;
  logic       trip_w;
  logic [2:0] ev;
  logic [2:0] w1c;

  assign act_int_w = st.act_int;
  assign act_usb_w = st.act_usb;

  // action 0 yields no term at all in any of the decodes below
  assign coast_int = lost_w[0] && act_int_w == comm_loss_pkg::ACT_COAST;  // RULE_01 RULE_02
  assign coast_usb = lost_w[1] && act_usb_w == comm_loss_pkg::ACT_COAST;  // RULE_09 RULE_10
  assign dec_int   = lost_w[0] && act_int_w == comm_loss_pkg::ACT_DECEL;  // RULE_03
  assign dec_usb   = lost_w[1] && act_usb_w == comm_loss_pkg::ACT_DECEL;  // RULE_11
  assign warn_int  = lost_w[0] && act_int_w == comm_loss_pkg::ACT_WARN;   // RULE_04
  assign warn_usb  = lost_w[1] && act_usb_w == comm_loss_pkg::ACT_WARN;   // RULE_12
  assign pre_int   = lost_w[0] && act_int_w == comm_loss_pkg::ACT_PRESET; // RULE_05
  assign pre_usb   = lost_w[1] && act_usb_w == comm_loss_pkg::ACT_PRESET; // RULE_13
  assign any_warn  = warn_int || warn_usb;
  assign trip_w    = coast_int || coast_usb || dec_int || dec_usb;        // RULE_07
  assign ev        = {trip_w, lost_w};
  assign w1c       = (reg_wr_i && reg_addr_i == comm_loss_pkg::ADDR_IRQ_STAT) ? reg_wdata_i[2:0] : 3'h0;

  always_comb begin
    next_st = st;

    // link status pins pass two flops before use
    next_st.ok_meta = {usb_link_ok_i, int_link_ok_i};
    next_st.ok_sync = st.ok_meta;

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        comm_loss_pkg::ADDR_CTRL: begin
          next_st.act_int = clamp_act(reg_wdata_i[comm_loss_pkg::CTRL_ACT_INT_LSB +: 3]);
          next_st.act_usb = clamp_act(reg_wdata_i[comm_loss_pkg::CTRL_ACT_USB_LSB +: 3]);
          next_st.speed_unit_select = reg_wdata_i[comm_loss_pkg::CTRL_RPM_BIT];
        end
        comm_loss_pkg::ADDR_INT_TIME:     next_st.int_time     = clamp_time(reg_wdata_i);
        comm_loss_pkg::ADDR_USB_TIME:     next_st.usb_time     = clamp_time(reg_wdata_i); // RULE_14
        comm_loss_pkg::ADDR_PRESET_FREQ:  next_st.preset_freq  = reg_wdata_i[15:0];
        comm_loss_pkg::ADDR_PRESET_SPEED: next_st.preset_speed = reg_wdata_i[15:0];
        comm_loss_pkg::ADDR_DECEL:        next_st.decel        = reg_wdata_i[15:0];
        comm_loss_pkg::ADDR_DO_SEL:       next_st.do_sel       = reg_wdata_i[23:0];
        comm_loss_pkg::ADDR_IRQ_MASK:     next_st.irq_mask     = reg_wdata_i[2:0];
        default: begin
        end
      endcase
    end

    // sticky events: a new rising edge wins over a same-cycle clear
    next_st.ev_prev  = ev;
    next_st.irq_stat = (st.irq_stat & ~w1c) | (ev & ~st.ev_prev);
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

    // register reads, data in the following cycle only
    next_st.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        comm_loss_pkg::ADDR_CTRL: begin
          next_st.rdata[comm_loss_pkg::CTRL_ACT_INT_LSB +: 3] = st.act_int;
          next_st.rdata[comm_loss_pkg::CTRL_ACT_USB_LSB +: 3] = st.act_usb;
          next_st.rdata[comm_loss_pkg::CTRL_RPM_BIT]          = st.speed_unit_select;
        end
        comm_loss_pkg::ADDR_INT_TIME:     next_st.rdata = {21'h000000, st.int_time};
        comm_loss_pkg::ADDR_USB_TIME:     next_st.rdata = {21'h000000, st.usb_time};
        comm_loss_pkg::ADDR_PRESET_FREQ:  next_st.rdata = {16'h0000, st.preset_freq};
        comm_loss_pkg::ADDR_PRESET_SPEED: next_st.rdata = {16'h0000, st.preset_speed};
        comm_loss_pkg::ADDR_DECEL:        next_st.rdata = {16'h0000, st.decel};
        comm_loss_pkg::ADDR_DO_SEL:       next_st.rdata = {8'h00, st.do_sel};
        comm_loss_pkg::ADDR_STATUS:       next_st.rdata = {26'h0000000, st.warn, st.trip,
                                                           st.ok_sync, st.lost};
        comm_loss_pkg::ADDR_IRQ_STAT:     next_st.rdata = {29'h00000000, st.irq_stat};
        comm_loss_pkg::ADDR_IRQ_MASK:     next_st.rdata = {29'h00000000, st.irq_mask};
        default:                          next_st.rdata = 32'h0000_0000;
      endcase
    end

    // actions
    next_st.lost  = lost_w;
    next_st.halt  = coast_int || coast_usb;                     // RULE_02 RULE_10
    next_st.dstop = (dec_int || dec_usb) && !next_st.halt;      // RULE_03 RULE_11
    next_st.dtime = st.decel;                                   // RULE_03 RULE_11
    next_st.trip  = trip_w;                                     // RULE_07
    next_st.prun  = (pre_int || pre_usb) && !trip_w;            // RULE_05 RULE_13
    next_st.warn  = any_warn || pre_int || pre_usb;             // RULE_08
    next_st.prpm  = st.speed_unit_select;                       // RULE_15
    next_st.pval  = st.speed_unit_select ? st.preset_speed : st.preset_freq; // RULE_15
    for (int k = 0; k < comm_loss_pkg::NUM_DO; k++) begin
      next_st.dout[k] = any_warn &&
        st.do_sel[k*comm_loss_pkg::DO_SEL_W +: comm_loss_pkg::DO_SEL_W] == comm_loss_pkg::DO_FN_LOST; // RULE_04 RULE_12
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st              <= '0;
      st.ok_meta      <= 2'h3;
      st.ok_sync      <= 2'h3;
      st.int_time     <= comm_loss_pkg::TIME_RESET;
      st.usb_time     <= comm_loss_pkg::TIME_RESET;
      st.preset_freq  <= comm_loss_pkg::PRESET_RESET;
      st.preset_speed <= comm_loss_pkg::PRESET_RESET;
      st.decel        <= comm_loss_pkg::DECEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_o                     = st.rdata;
  assign free_run_halt_o                 = st.halt;
  assign decel_stop_o                    = st.dstop;
  assign trip_decel_time_o               = st.dtime;
  assign preset_run_o                    = st.prun;
  assign preset_is_rpm_o                 = st.prpm;
  assign preset_value_o                  = st.pval;
  assign trip_o                          = st.trip;
  assign warning_o                       = st.warn;
  assign multifunction_digital_outputs_o = st.dout;
  assign int_lost_o                      = st.lost[0];
  assign usb_lost_o                      = st.lost[1];
  assign irq_o                           = st.irq;

endmodule : comm_loss_supervisor
`default_nettype wire

// ==== sim/comm_loss_supervisor_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module comm_loss_supervisor_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        int_link_ok_i,
  input wire logic        usb_link_ok_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        free_run_halt_o,
  input wire logic        decel_stop_o,
  input wire logic        preset_run_o,
  input wire logic        trip_o,
  input wire logic        warning_o,
  input wire logic [2:0]  multifunction_digital_outputs_o,
  input wire logic        int_lost_o,
  input wire logic        usb_lost_o,
  input wire logic        irq_o
);
  // ****************************************************************
  // run length of each link being low
  // ****************************************************************
  int int_low;
  int usb_low;
  always_ff @(posedge clk_sys_i) begin
    int_low <= (sys_rst_i || int_link_ok_i) ? 0 : int_low + 1;
    usb_low <= (sys_rst_i || usb_link_ok_i) ? 0 : usb_low + 1;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence int_ok_run;
    int_link_ok_i [*5];
  endsequence
  sequence usb_ok_run;
    usb_link_ok_i [*5];
  endsequence

  a_int_timer_restart: assert property (int_ok_run |=> !int_lost_o)
    else $error("internal loss held after link recovered");
  a_usb_timer_restart: assert property (usb_ok_run |=> !usb_lost_o)
    else $error("usb loss held after link recovered");
  // shortest limit is one tick; sync, timer and output flops add three cycles
  a_int_loss_persist: assert property ($rose(int_lost_o) |-> int_low >= TICK_CYCLES + 3)
    else $error("internal loss declared too early");
  a_usb_loss_persist: assert property ($rose(usb_lost_o) |-> usb_low >= TICK_CYCLES + 3)
    else $error("usb loss declared too early");
  a_halt_is_trip: assert property (free_run_halt_o |-> trip_o && !decel_stop_o && !preset_run_o)
    else $error("halt without trip");
  a_decel_is_trip: assert property (decel_stop_o |-> trip_o && !preset_run_o)
    else $error("decel stop without trip");
  a_preset_warns: assert property (preset_run_o |-> warning_o && !trip_o)
    else $error("preset run not a warning");
  a_output_warns: assert property (multifunction_digital_outputs_o != 3'h0 |-> warning_o)
    else $error("digital output without warning");
  a_quiet_no_loss: assert property (!(int_lost_o || usb_lost_o) |-> !(trip_o || warning_o))
    else $error("action without declared loss");
  a_rdata_after_read: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
    else $error("read data outside read slot");
  a_irq_has_cause: assert property ($rose(irq_o) |-> $rose(int_lost_o) || $rose(usb_lost_o) || $rose(trip_o)
    || $past(reg_wr_i))
    else $error("interrupt without event");
endmodule : comm_loss_supervisor_monitor

bind comm_loss_supervisor comm_loss_supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) comm_loss_supervisor_monitor_i (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .int_link_ok_i(int_link_ok_i), .usb_link_ok_i(usb_link_ok_i),
  .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .free_run_halt_o(free_run_halt_o),
  .decel_stop_o(decel_stop_o), .preset_run_o(preset_run_o), .trip_o(trip_o), .warning_o(warning_o),
  .multifunction_digital_outputs_o(multifunction_digital_outputs_o), .int_lost_o(int_lost_o),
  .usb_lost_o(usb_lost_o), .irq_o(irq_o));
`default_nettype wire

// ==== sim/link_partner_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
  input  wire logic int_drop_i,
  input  wire logic usb_drop_i,
  output wire logic int_link_ok_o,
  output wire logic usb_link_ok_o
);
  // links change off the clock grid, as the real far side does
  assign #3 int_link_ok_o = !int_drop_i;
  assign #3 usb_link_ok_o = !usb_drop_i;
endmodule : link_partner_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TICK = 4;
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        int_drop  = 1'b0;
  logic        usb_drop  = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  wire         int_link_ok;
  wire         usb_link_ok;
  logic [31:0] reg_rdata;
  logic        halt, decel, preset_run, is_rpm, trip, warning, int_lost, usb_lost, irq;
  logic [15:0] decel_time, preset_value;
  logic [2:0]  mfdo;
  int          errors      = 0;
  int          check_count = 0;

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  comm_loss_supervisor #(.TICK_CYCLES(TICK)) comm_loss_supervisor_i (
    .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .int_link_ok_i(int_link_ok), .usb_link_ok_i(usb_link_ok),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .free_run_halt_o(halt), .decel_stop_o(decel), .trip_decel_time_o(decel_time),
    .preset_run_o(preset_run), .preset_is_rpm_o(is_rpm), .preset_value_o(preset_value), .trip_o(trip),
    .warning_o(warning), .multifunction_digital_outputs_o(mfdo), .int_lost_o(int_lost),
    .usb_lost_o(usb_lost), .irq_o(irq));
  link_partner_model link_partner_model_i (.int_drop_i(int_drop), .usb_drop_i(usb_drop),
    .int_link_ok_o(int_link_ok), .usb_link_ok_o(usb_link_ok));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  task automatic set_drop(input bit u, input logic v);
    @(posedge clk_sys);
    if (u) usb_drop <= v; else int_drop <= v;
  endtask : set_drop

  task automatic wait_lost(input bit u, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((u ? usb_lost : int_lost) !== v && n < 300);
  endtask : wait_lost

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [3:0] z [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hf};
    rd(4'h1, 32'(comm_loss_pkg::TIME_RESET));
    rd(4'h2, 32'(comm_loss_pkg::TIME_RESET));
    foreach (z[i]) rd(z[i], 32'h0);
    wr(4'h0, 32'h77);
    rd(4'h0, 32'h0);
    wr(4'h1, 32'h0000ffff);
    rd(4'h1, 32'(comm_loss_pkg::TIME_MAX));
    wr(4'h1, 32'h0);
    rd(4'h1, 32'h1);
    wr(4'h2, 32'h0);
    rd(4'h2, 32'h1);
    wr(4'h7, 32'h3f);
    rd(4'h7, 32'h0c);
    wr(4'h3, 32'h1234);
    wr(4'h4, 32'h0567);
    wr(4'h5, 32'h0abc);
    wr(4'h6, 32'h0e0d00);
  endtask : t_regs

  task automatic t_act(input bit u, input logic [2:0] a);
    int n;
    logic [7:0] e;
    wr(4'h0, (32'(a) << (u ? 4 : 0)) | (u ? 32'h100 : 32'h0));
    set_drop(u, 1'b1);
    wait_lost(u, 1'b1, n);
    chk(32'(n >= TICK && n <= TICK + 7), 32'h1);
    e = {a == 3'h2, a == 3'h1, a inside {3'h1, 3'h2}, a inside {3'h3, 3'h4}, a == 3'h4, a == 3'h3 ? 3'h2 : 3'h0};
    chk({24'h0, decel, halt, trip, warning, preset_run, mfdo}, {24'h0, e});
    chk({15'h0, is_rpm, preset_value}, {15'h0, u, u ? 16'h0567 : 16'h1234});
    chk({16'h0, decel_time}, 32'h0abc);
    set_drop(u, 1'b0);
    wait_lost(u, 1'b0, n);
    chk(32'(n == 4), 32'h1);
    chk({24'h0, decel, halt, trip, warning, preset_run, mfdo}, 32'h0);
  endtask : t_act

  task automatic t_restart;
    int n;
    logic s = 1'b0;
    wr(4'h1, 32'h2);
    wr(4'h0, 32'h1);
    repeat (2) begin
      set_drop(1'b0, 1'b1);
      repeat (6) begin
        @(posedge clk_sys);
        #1;
        s = s | int_lost;
      end
      set_drop(1'b0, 1'b0);
      repeat (3) @(posedge clk_sys);
    end
    chk({31'h0, s}, 32'h0);
    set_drop(1'b0, 1'b1);
    wait_lost(1'b0, 1'b1, n);
    chk(32'(n >= 2 * TICK && n <= 2 * TICK + 7), 32'h1);
    set_drop(1'b0, 1'b0);
    wait_lost(1'b0, 1'b0, n);
    wr(4'h1, 32'h1);
  endtask : t_restart

  task automatic t_irq;
    int n;
    wr(4'h8, 32'h7);
    wr(4'h9, 32'h1);
    for (int m = 1; m >= 0; m--) begin
      wr(4'h0, 32'h0);
      set_drop(1'b0, 1'b1);
      wait_lost(1'b0, 1'b1, n);
      @(posedge clk_sys);
      #1;
      chk({31'h0, irq}, 32'(m));
      rd(4'h8, 32'h1);
      set_drop(1'b0, 1'b0);
      wait_lost(1'b0, 1'b0, n);
      chk({31'h0, irq}, 32'(m));
      wr(4'h8, 32'h1);
      @(posedge clk_sys);
      #1;
      chk({31'h0, irq}, 32'h0);
      rd(4'h8, 32'h0);
      wr(4'h9, 32'h0);
    end
  endtask : t_irq

  task tally_and_finish;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    for (int u = 0; u < 2; u++) begin
      for (int a = 0; a < 5; a++) t_act(u[0], 3'(a));
    end
    t_restart;
    t_irq;
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
